// ### ext_interrupt_vector_map.v
// interrupt vector mapping, wake-up qualification and external sensitivity control
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_map.vh"

// How it works
// - fixed priority, vectors FFFA down to FFE0
// - time base wakes only from active halt
// - only listed sources wake from halt
// - CAN status vector wakes on bus wake-up
// - voltage detector request never wakes
// - serial unit wakes only via receive pin
// - four independent two-bit sensitivity fields
// - 00 fall+low, 01 rise, 10 fall, 11 both
// - sensitivity writes only at priority level 3
// - changed field clears that line's pending request
// - edge-select bit picks falling or rising edge
// - edge select writable only while disabled
// - enable bit gates the top-level pin
// - clearing enable may raise a spurious interrupt
// - edge requests latched, cleared on service entry
// - selected pins of one group are ORed
// - top-level pin ignores current level 3
// - masked requests stay latched and pending
module ext_interrupt_vector_map (
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output wire [31:0] dat_o,
    output wire        ack_o,
    // pins
    input  wire [15:0] ext_pin_i,
    input  wire [15:0] ext_pin_sel_i,
    input  wire        top_pin_i,
    // peripheral request levels
    input  wire        time_base_req_i,
    input  wire        auto_wake_req_i,
    input  wire        aux_voltage_req_i,
    input  wire        can_rx_req_i,
    input  wire        can_tx_req_i,
    input  wire        can_wakeup_i,
    input  wire        spi_req_i,
    input  wire        timer8_req_i,
    input  wire        timer16_req_i,
    input  wire        serial2_req_i,
    input  wire        serial1_req_i,
    input  wire        pulse_timer_req_i,
    // core side
    input  wire        cur_prio_hi_i,
    input  wire        cur_prio_lo_i,
    input  wire [27:0] vec_prio_i,
    input  wire        halt_i,
    input  wire        active_halt_i,
    input  wire        irq_enter_i,
    input  wire [3:0]  irq_enter_idx_i,
    output wire        irq_req_o,
    output wire [3:0]  irq_index_o,
    output wire [15:0] irq_vector_o,
    output wire        wake_o
);

    // ****************************************************************
    // level decode of a two-bit priority code
    // ****************************************************************
    function [1:0] prio_rank;
        input [1:0] code;
        begin
            case (code)
                2'h2:    prio_rank = 2'h0;
                2'h1:    prio_rank = 2'h1;
                2'h0:    prio_rank = 2'h2;
                default: prio_rank = 2'h3;
            endcase
        end
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    reg [15:0] ext_meta_reg;
    reg [15:0] ext_sync_reg;
    reg        top_meta_reg;
    reg        top_sync_reg;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ext_meta_reg <= 16'hFFFF;
            ext_sync_reg <= 16'hFFFF;
            top_meta_reg <= 1'b1;
            top_sync_reg <= 1'b1;
        end else begin
            ext_meta_reg <= ext_pin_i;
            ext_sync_reg <= ext_meta_reg;
            top_meta_reg <= top_pin_i;
            top_sync_reg <= top_meta_reg;
        end
    end

    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    reg  [7:0]  ext_line_sensitivity_reg;
    reg  [1:0]  top_level_pin_control_reg;
    reg         ack_reg;
    reg  [31:0] dat_reg;
    reg  [31:0] rd_data;
    wire        access;
    wire        wr_lane0;
    wire        wr_sense;
    wire        wr_ctrl;
    wire        level3;
    wire        top_pin_edge_sel;
    wire        top_pin_irq_en;

    // one wait state: ack follows the first cycle of the request
    assign access   = cyc_i & stb_i & ~ack_reg;
    assign wr_lane0 = access & we_i & sel_i[0];
    assign level3   = ({cur_prio_hi_i, cur_prio_lo_i} == `PRIO_LEVEL3);
    assign wr_sense = wr_lane0 & (adr_i == `OFS_EXT_LINE_SENSITIVITY) & level3;
    assign wr_ctrl  = wr_lane0 & (adr_i == `OFS_TOP_LEVEL_PIN_CONTROL);

    assign top_pin_edge_sel = top_level_pin_control_reg[`TOP_PIN_EDGE_SEL_BIT];
    assign top_pin_irq_en   = top_level_pin_control_reg[`TOP_PIN_IRQ_EN_BIT];

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg                   <= 1'b0;
            ext_line_sensitivity_reg  <= `EXT_LINE_SENSITIVITY_RST;
            top_level_pin_control_reg <= `TOP_LEVEL_PIN_CONTROL_RST;
        end else begin
            ack_reg <= access;
            if (wr_sense) begin
                ext_line_sensitivity_reg <= dat_i[7:0];
            end
            if (wr_ctrl) begin
                top_level_pin_control_reg[`TOP_PIN_IRQ_EN_BIT] <=
                    dat_i[`TOP_PIN_IRQ_EN_BIT];
                if (!top_pin_irq_en) begin
                    top_level_pin_control_reg[`TOP_PIN_EDGE_SEL_BIT] <=
                        dat_i[`TOP_PIN_EDGE_SEL_BIT];
                end
            end
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    // ****************************************************************
    // top-level pin
    // ****************************************************************
    reg  top_prev_reg;
    reg  top_pend_reg;
    wire top_edge;
    wire top_disable;
    wire top_spurious;
    wire top_set;
    wire top_clear;

    assign top_edge = top_pin_edge_sel ? (top_sync_reg & ~top_prev_reg)
                                       : (~top_sync_reg & top_prev_reg);
    // the gate collapsing as enable drops looks like an edge when the
    // pin already sits at the level that the selected edge ends on
    assign top_disable  = wr_ctrl & top_pin_irq_en & ~dat_i[`TOP_PIN_IRQ_EN_BIT];
    assign top_spurious = top_disable & (top_sync_reg == top_pin_edge_sel);
    assign top_set      = (top_pin_irq_en & top_edge) | top_spurious;
    assign top_clear    = irq_enter_i & (irq_enter_idx_i == `VEC_IDX_TOP_PIN);

    always @(posedge clk_i) begin
        if (rst_i) begin
            top_prev_reg <= 1'b1;
            top_pend_reg <= 1'b0;
        end else begin
            top_prev_reg <= top_sync_reg;
            top_pend_reg <= top_set | (top_pend_reg & ~top_clear);
        end
    end

    // ****************************************************************
    // external lines
    // ****************************************************************
    wire [15:0] pin_low_sel;
    wire [3:0]  line_req;

    // selected pins are ORed as active-low requests, unselected pins idle
    assign pin_low_sel = ~ext_sync_reg & ext_pin_sel_i;

    genvar k;
    generate
        for (k = 0; k < `NUM_LINES; k = k + 1) begin : g_line
            wire [1:0] cur_field;
            wire [1:0] new_field;
            wire       field_change;
            wire       line_clear;
            wire       line_level;

            assign cur_field    = ext_line_sensitivity_reg[2*k+1:2*k];
            assign new_field    = dat_i[2*k+1:2*k];
            assign field_change = wr_sense & (new_field != cur_field);
            assign line_clear   = field_change |
                (irq_enter_i & ({28'h0000000, irq_enter_idx_i} == `VEC_IDX_EXT0 + k));
            assign line_level   = ~(|pin_low_sel[`PINS_PER_LINE*k+3:`PINS_PER_LINE*k]);

            ext_line_detect u_det (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .pin_i   (line_level),
                .sense_i (cur_field),
                .clear_i (line_clear),
                .req_o   (line_req[k])
            );
        end
    endgenerate

    // ****************************************************************
    // pending vector, index order equals hardware priority
    // ****************************************************************
    wire [13:0] pending;

    assign pending = {pulse_timer_req_i,
                      serial1_req_i,
                      serial2_req_i,
                      timer16_req_i,
                      timer8_req_i,
                      spi_req_i,
                      can_tx_req_i,
                      can_rx_req_i,
                      line_req[3],
                      line_req[2],
                      line_req[1] | aux_voltage_req_i,
                      line_req[0] | auto_wake_req_i,
                      time_base_req_i,
                      top_pend_reg};

    // ****************************************************************
    // halt exit qualification
    // ****************************************************************
    reg  [13:0] wake_src;
    wire [13:0] wake_cap;

    // vector 3 is qualified by its external line alone, so the shared voltage
    // detector cannot wake the part; vector 2 also passes the auto-wake source
    always @* begin
        wake_src = pending;
        wake_src[`VEC_IDX_EXT0]       = line_req[0] | auto_wake_req_i;
        wake_src[`VEC_IDX_EXT0 + 4'h1] = line_req[1];
    end

    assign wake_cap = `WAKE_FULL_HALT |
        (active_halt_i ? `WAKE_ACTIVE_HALT_ONLY : 14'h0000) |
        ({13'h0000, can_wakeup_i} << `VEC_IDX_CAN_TX);
    // the serial unit 1 bit is absent from both masks; its receive pin
    // reaches the core only through an external line
    wire [13:0] wake_hit;
    assign wake_hit = wake_src & wake_cap;

    // ****************************************************************
    // arbitration
    // ****************************************************************
    reg  [13:0] eligible;
    reg  [3:0]  win_idx;
    reg         win_any;
    wire [1:0]  cur_rank;
    integer     i;

    assign cur_rank = prio_rank({cur_prio_hi_i, cur_prio_lo_i});

    always @* begin
        eligible = 14'h0000;
        win_idx  = 4'h0;
        win_any  = 1'b0;
        for (i = 0; i < `NUM_VEC; i = i + 1) begin
            // not-above-level requests stay pending, just not offered
            eligible[i] = pending[i] &
                (prio_rank(vec_prio_i[2*i+:2]) > cur_rank);
        end
        eligible[`VEC_IDX_TOP_PIN] = top_pend_reg;
        if (halt_i) begin
            eligible = eligible & wake_hit;
        end
        for (i = `NUM_VEC - 1; i >= 0; i = i - 1) begin
            if (eligible[i]) begin
                win_idx = i[3:0];
                win_any = 1'b1;
            end
        end
    end

    reg        irq_req_reg;
    reg [3:0]  irq_index_reg;
    reg [15:0] irq_vector_reg;
    reg        wake_reg;

    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_req_reg    <= 1'b0;
            irq_index_reg  <= 4'h0;
            irq_vector_reg <= `VEC_TOP_ADDR;
            wake_reg       <= 1'b0;
        end else begin
            irq_req_reg    <= win_any;
            irq_index_reg  <= win_idx;
            irq_vector_reg <= `VEC_TOP_ADDR - {11'h000, win_idx, 1'b0};
            wake_reg       <= halt_i & (|wake_hit);
        end
    end

    assign irq_req_o    = irq_req_reg;
    assign irq_index_o  = irq_index_reg;
    assign irq_vector_o = irq_vector_reg;
    assign wake_o       = wake_reg;

    // ****************************************************************
    // read back
    // ****************************************************************
    always @* begin
        rd_data = 32'h00000000;
        case (adr_i)
            `OFS_EXT_LINE_SENSITIVITY: begin
                rd_data[7:0] = ext_line_sensitivity_reg;
            end
            `OFS_TOP_LEVEL_PIN_CONTROL: begin
                rd_data[1:0] = top_level_pin_control_reg;
            end
            `OFS_PENDING_STATUS: begin
                rd_data[13:0] = pending;
            end
            `OFS_SERVICE_STATUS: begin
                rd_data[`SVC_REQ_BIT]                   = irq_req_reg;
                rd_data[`SVC_WAKE_BIT]                  = wake_reg;
                rd_data[`SVC_INDEX_MSB:`SVC_INDEX_LSB]   = irq_index_reg;
                rd_data[`SVC_VECTOR_MSB:`SVC_VECTOR_LSB] = irq_vector_reg;
            end
            default: begin
                rd_data = 32'h00000000;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h00000000;
        end else if (access && !we_i) begin
            dat_reg <= rd_data;
        end
    end

endmodule // ext_interrupt_vector_map

`default_nettype wire

// ### ext_irq_map.vh
// offsets, field positions, reset values and vector constants of the interrupt block
`ifndef EXT_IRQ_MAP_VH
`define EXT_IRQ_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_EXT_LINE_SENSITIVITY 8'h00
`define OFS_TOP_LEVEL_PIN_CONTROL 8'h04
`define OFS_PENDING_STATUS 8'h08
`define OFS_SERVICE_STATUS 8'h0C

// ****************************************************************
// reset values and field positions
// ****************************************************************
`define EXT_LINE_SENSITIVITY_RST 8'h00
`define TOP_LEVEL_PIN_CONTROL_RST 2'h0
`define TOP_PIN_EDGE_SEL_BIT 1
`define TOP_PIN_IRQ_EN_BIT 0
`define SVC_REQ_BIT 0
`define SVC_WAKE_BIT 1
`define SVC_INDEX_LSB 4
`define SVC_INDEX_MSB 7
`define SVC_VECTOR_LSB 16
`define SVC_VECTOR_MSB 31

// ****************************************************************
// sizes
// ****************************************************************
`define NUM_LINES 4
`define PINS_PER_LINE 4
`define NUM_PINS 16
`define NUM_VEC 14

// ****************************************************************
// sensitivity codes and priority level
// ****************************************************************
`define SENSE_FALL_LOW 2'h0
`define SENSE_RISE 2'h1
`define SENSE_FALL 2'h2
`define SENSE_BOTH 2'h3
`define PRIO_LEVEL3 2'h3

// ****************************************************************
// vectors: index 0 is highest hardware priority
// ****************************************************************
`define VEC_TOP_ADDR 16'hFFFA
`define VEC_IDX_TOP_PIN 4'h0
`define VEC_IDX_TIME_BASE 4'h1
`define VEC_IDX_EXT0 4'h2
`define VEC_IDX_CAN_TX 4'h7
`define WAKE_FULL_HALT 14'h213D
`define WAKE_ACTIVE_HALT_ONLY 14'h0002

`endif

// ### ext_irq_map_monitor.sv
// port-level assertion checker for the interrupt vector map
`timescale 1ns/1ps
`default_nettype none
module irq_map_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic        halt_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        irq_req_o,
    input wire logic [3:0]  irq_index_o,
    input wire logic [15:0] irq_vector_o,
    input wire logic        wake_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rd;
    assign rd = cyc_i && stb_i && !ack_o && !we_i;
    // ****************************************************************
    // bus and vector relations
    // ****************************************************************
    ack_once_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    vec_map_a: assert property (
        irq_req_o |-> irq_vector_o == 16'hFFFA - {11'h0, irq_index_o, 1'b0})
        else $error("vector does not match index");
    vec_range_a: assert property (irq_req_o |-> irq_index_o < 4'hE)
        else $error("index beyond last vector");
    wake_halt_a: assert property (wake_o |-> $past(halt_i))
        else $error("wake outside halt");
    status_vec_a: assert property (
        rd && adr_i == 8'h0C |=> dat_o[31:16] == 16'hFFFA - {11'h0, dat_o[7:4], 1'b0})
        else $error("status vector mismatch");
    pend_width_a: assert property (rd && adr_i == 8'h08 |=> dat_o[31:14] == 18'h0)
        else $error("pending bits beyond vectors");
    reset_out_a: assert property (
        $past(rst_i) |-> !ack_o && !irq_req_o && !wake_o && irq_vector_o == 16'hFFFA)
        else $error("outputs not at reset state");
endmodule // irq_map_checker

bind ext_interrupt_vector_map irq_map_checker u_irq_map_checker (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .halt_i(halt_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_req_o(irq_req_o), .irq_index_o(irq_index_o),
    .irq_vector_o(irq_vector_o), .wake_o(wake_o));
`default_nettype wire

// ### ext_line_detect.v
// sensitivity detector and request latch of one external interrupt line
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_map.vh"

module ext_line_detect (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       pin_i,
    input  wire [1:0] sense_i,
    input  wire       clear_i,
    output wire       req_o
);

    reg  prev_reg;
    reg  latch_reg;
    wire rise;
    wire fall;
    reg  hit;

    assign rise = pin_i & ~prev_reg;
    assign fall = ~pin_i & prev_reg;

    always @* begin
        case (sense_i)
            `SENSE_FALL_LOW: hit = fall;
            `SENSE_RISE:     hit = rise;
            `SENSE_FALL:     hit = fall;
            `SENSE_BOTH:     hit = rise | fall;
            default:         hit = 1'b0;
        endcase
    end

    // idle level of a pulled-up pin is high, so no edge is seen at reset
    always @(posedge clk_i) begin
        if (rst_i) begin
            prev_reg  <= 1'b1;
            latch_reg <= 1'b0;
        end else begin
            prev_reg  <= pin_i;
            // set wins over clear so an edge in the clearing cycle survives
            latch_reg <= hit | (latch_reg & ~clear_i);
        end
    end

    // low level keeps the request up after the falling edge
    assign req_o = latch_reg | ((sense_i == `SENSE_FALL_LOW) & ~pin_i);

endmodule // ext_line_detect

`default_nettype wire

// ### irq_core_model.sv
// behavioural core that takes offered requests and enters their service
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       take_i,
    input  wire logic       slow_i,
    input  wire logic       req_i,
    input  wire logic [3:0] idx_i,
    output logic            enter_o,
    output logic [3:0]      enter_idx_o
);
    // ****************************************************************
    // service entry
    // ****************************************************************
    logic [3:0] cnt_reg;
    // idle index toggles so nothing can rely on a stale value
    always @(posedge clk_i) begin
        enter_o <= 1'b0;
        enter_idx_o <= ~enter_idx_o;
        if (rst_i) begin
            cnt_reg <= 4'h0;
            enter_idx_o <= 4'h0;
        end else if (take_i && req_i && !enter_o && cnt_reg >= (slow_i ? 4'h8 : 4'h2)) begin
            enter_o <= 1'b1;
            enter_idx_o <= idx_i;
            cnt_reg <= 4'h0;
        end else if (take_i && req_i) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule // core_model
`default_nettype wire

// ### testbench.sv
// self-checking bench for the interrupt vector map
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0;
    logic [15:0] ext_pin_i = 16'hFFFF;
    logic [15:0] ext_pin_sel_i = 16'h1131;
    logic        top_pin_i = 1'b1;
    logic        auto_wake_req_i = 1'b0;
    logic [10:0] per = 11'h0;
    logic        cur_prio_hi_i = 1'b1;
    logic        cur_prio_lo_i = 1'b1;
    logic [27:0] vec_prio_i = 28'hFFFFFFF;
    logic        halt_i = 1'b0;
    logic        active_halt_i = 1'b0;
    logic        take_en = 1'b0;
    logic        slow = 1'b0;
    wire         time_base_req_i, aux_voltage_req_i, can_rx_req_i, can_tx_req_i;
    wire         can_wakeup_i, spi_req_i, timer8_req_i, timer16_req_i;
    wire         serial2_req_i, serial1_req_i, pulse_timer_req_i;
    wire [31:0]  dat_o;
    wire         ack_o, irq_req_o, wake_o, irq_enter_i;
    wire [3:0]   irq_index_o, irq_enter_idx_i;
    wire [15:0]  irq_vector_o;
    int          bad_count = 0;
    int          checks = 0;
    // {active halt, source levels, expected wake}
    logic [12:0] wk [12] = '{13'h0800, 13'h1801, 13'h0400, 13'h0200, 13'h0100, 13'h0181,
                             13'h0041, 13'h0020, 13'h0010, 13'h0008, 13'h0004, 13'h0003};
    assign {time_base_req_i, aux_voltage_req_i, can_rx_req_i, can_tx_req_i, can_wakeup_i,
            spi_req_i, timer8_req_i, timer16_req_i, serial2_req_i, serial1_req_i,
            pulse_timer_req_i} = per;
    ext_interrupt_vector_map u_ext_interrupt_vector_map (.*);
    core_model u_core_model (.clk_i(clk_i), .rst_i(rst_i), .take_i(take_en), .slow_i(slow),
        .req_i(irq_req_o), .idx_i(irq_index_o), .enter_o(irq_enter_i),
        .enter_idx_o(irq_enter_idx_i));
    always #4 clk_i = ~clk_i;
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
            if (n > 50) begin
                bad_count++;
                end_sim();
            end
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h0, q);
        chk(q, e);
    endtask
    task automatic wait_req;
        int n;
        n = 0;
        while (irq_req_o !== 1'b1) begin
            @(posedge clk_i);
            n++;
            if (n > 40) begin
                bad_count++;
                end_sim();
            end
        end
    endtask
    // level 0 lets the core take the request; level 3 again afterwards
    task automatic serve;
        {cur_prio_hi_i, cur_prio_lo_i} <= 2'b10;
        take_en <= 1'b1;
        tick(14);
        take_en <= 1'b0;
        {cur_prio_hi_i, cur_prio_lo_i} <= 2'b11;
        tick(2);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h10, 32'h0);
        {cur_prio_hi_i, cur_prio_lo_i} <= 2'b10;
        wr(8'h00, 32'hB4);
        rd(8'h00, 32'h0);
        {cur_prio_hi_i, cur_prio_lo_i} <= 2'b11;
        sel_i <= 4'hE;
        wr(8'h00, 32'hB4);
        rd(8'h00, 32'h0);
        sel_i <= 4'hF;
        wr(8'h00, 32'hB4);
        rd(8'h00, 32'hB4);
        for (int c = 3; c >= 0; c--) begin
            wr(8'h00, {24'h0, 6'h2D, c[1:0]});
            slow <= (c == 2);
            ext_pin_i[0] <= 1'b0;
            tick(5);
            rd(8'h08, {29'h0, c != 1, 2'h0});
            chk({31'h0, irq_req_o}, 32'h0);
            ext_pin_i[0] <= 1'b1;
            tick(5);
            rd(8'h08, 32'h4);
            {cur_prio_hi_i, cur_prio_lo_i} <= 2'b10;
            wait_req();
            chk({16'h0, irq_vector_o}, 32'hFFF6);
            serve();
            rd(8'h08, 32'h0);
        end
        wr(8'h00, 32'hB6);
        ext_pin_i[0] <= 1'b0;
        tick(5);
        wr(8'h00, 32'hB6);
        rd(8'h08, 32'h4);
        wr(8'h00, 32'hB7);
        rd(8'h08, 32'h0);
        wr(8'h00, 32'hB4);
        tick(4);
        serve();
        rd(8'h08, 32'h4);
        ext_pin_i[0] <= 1'b1;
        tick(5);
        rd(8'h08, 32'h0);
        ext_pin_i[5:4] <= 2'b00;
        tick(5);
        ext_pin_i[5] <= 1'b1;
        tick(5);
        rd(8'h08, 32'h0);
        ext_pin_i[4] <= 1'b1;
        tick(5);
        rd(8'h08, 32'h8);
        serve();
        top_pin_i <= 1'b0;
        tick(5);
        rd(8'h08, 32'h0);
        top_pin_i <= 1'b1;
        wr(8'h04, 32'h1);
        tick(4);
        top_pin_i <= 1'b0;
        wait_req();
        chk({28'h0, irq_index_o}, 32'h0);
        wr(8'h04, 32'h3);
        rd(8'h04, 32'h1);
        serve();
        rd(8'h08, 32'h0);
        wr(8'h04, 32'h0);
        tick(2);
        rd(8'h08, 32'h1);
        serve();
        wr(8'h04, 32'h2);
        rd(8'h04, 32'h2);
        wr(8'h04, 32'h3);
        top_pin_i <= 1'b1;
        tick(5);
        rd(8'h08, 32'h1);
        serve();
        wr(8'h04, 32'h0);
        serve();
        {cur_prio_hi_i, cur_prio_lo_i} <= 2'b10;
        per <= 11'h021;
        wait_req();
        tick(2);
        chk({16'h0, irq_vector_o}, 32'hFFEA);
        per <= 11'h001;
        tick(3);
        chk({28'h0, irq_index_o}, 32'hD);
        rd(8'h0C, 32'hFFE000D1);
        per <= 11'h0;
        {cur_prio_hi_i, cur_prio_lo_i} <= 2'b11;
        halt_i <= 1'b1;
        tick(3);
        for (int i = 0; i < 12; i++) begin
            {active_halt_i, per} <= wk[i][12:1];
            tick(4);
            chk({31'h0, wake_o}, {31'h0, wk[i][0]});
            per <= 11'h0;
            active_halt_i <= 1'b0;
            tick(4);
        end
        auto_wake_req_i <= 1'b1;
        tick(4);
        chk({31'h0, wake_o}, 32'h1);
        auto_wake_req_i <= 1'b0;
        tick(4);
        ext_pin_i[0] <= 1'b0;
        tick(6);
        chk({31'h0, wake_o}, 32'h1);
        ext_pin_i[0] <= 1'b1;
        halt_i <= 1'b0;
        wr(8'h00, 32'hB6);
        end_sim();
    end
endmodule // testbench
`default_nettype wire
